// [src/rx_intake_pkg.sv]
// Package for the receiver sample intake and status block.
// Assumes one 50 MHz system clock; all backplane and host signals arrive as plain ports.
package rx_intake_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BEAT_PERIOD_MS  = 500;
  localparam int unsigned BEAT_OFF_MS     = 20;
  localparam int unsigned BEAT_PERIOD_CYC = CLK_HZ / 1000 * BEAT_PERIOD_MS;
  localparam int unsigned BEAT_OFF_CYC    = CLK_HZ / 1000 * BEAT_OFF_MS;
  localparam int unsigned INIT_CYC        = 16;
  localparam int unsigned SAMPLE_W        = 16;
  localparam int unsigned BASIC_W         = 12;
  localparam int unsigned ACC_DEPTH       = 64;
  localparam int unsigned ACC_AW          = 6;
  localparam int unsigned ACC_W           = 32;
  localparam int unsigned WORK_MEM_BYTES  = 4 * 1024 * 1024;
  localparam int unsigned STORE_MEM_BYTES = 16 * 1024 * 1024;
  localparam int unsigned TRIG_W          = 16;
  localparam logic [ACC_AW-1:0] ADDR_ZERO = 6'h00;

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_ACQ, ST_SEND} phase_e;

  // One outgoing accumulated word with its fast-link copy flag.
  typedef struct packed {
    logic             link_copy;
    logic [ACC_W-1:0] data;
  } out_word_s;
endpackage : rx_intake_pkg

// [src/receiver_sample_intake_status.sv]
// Sample intake, accumulation, output buffering and front-panel status logic.
// Assumes gate inputs come from the backplane (synchronised here) and that
// the sample word and its valid arrive on sys_clk from the digitizer interface.
// Summary of operation
// - Take samples only while accept gate high
// - Extended variant 16-bit, basic 12-bit samples
// - Ready on, off 20 ms every 500 ms
// - Acquisition indicator lit during acquisition
// - Transmit indicator lit while sending to host
// - Receive indicator lit while host data arrives
// - Intake sustains two 20 MHz streams
// - Working and storage memory sizes provided
// - Accumulate over scans, buffer, send to host
// - Extended variant also streams on fast link
// - Forward amplifier display data to host
// - Configuration command discovers rack units
// - Relay host traffic to rack units
// - Extended variant has programmable trigger output
// - Store samples when digitizer gate, else zeros
// - All timing from common backplane clock
module receiver_sample_intake_status
  import rx_intake_pkg::*;
#(
  parameter bit          EXTENDED  = 1'b1,
  parameter int unsigned PERIOD_CYC = BEAT_PERIOD_CYC,
  parameter int unsigned OFF_CYC    = BEAT_OFF_CYC,
  parameter int unsigned SCAN_LEN   = ACC_DEPTH
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Backplane gates from the observe signal generator.
  input  wire logic                accept_gate,
  input  wire logic                digitizer_gate,
  // Sample words from the receiver digitizer, two per clock slot.
  input  wire logic [SAMPLE_W-1:0] sample_a,
  input  wire logic [SAMPLE_W-1:0] sample_b,
  input  wire logic                sample_valid,
  // Acquisition control.
  input  wire logic [15:0]         scan_count,
  // Host side result stream.
  output logic [ACC_W-1:0]         host_data,
  output logic                     host_valid,
  input  wire logic                host_ready,
  // Fast link stream to the real-time controller.
  output logic [ACC_W-1:0]         link_data,
  output logic                     link_valid,
  // Inward host traffic and relay to rack units.
  input  wire logic [7:0]          host_rx_data,
  input  wire logic                host_rx_valid,
  output logic [7:0]               rack_data,
  output logic                     rack_valid,
  input  wire logic                cfg_command,
  input  wire logic [7:0]          slot_present,
  output logic [7:0]               rack_map,
  output logic                     rack_map_valid,
  // Amplifier display data from the backplane serial bus.
  input  wire logic [7:0]          amp_display_byte,
  input  wire logic                amp_display_valid,
  output logic [7:0]               amp_fwd_data,
  output logic                     amp_fwd_valid,
  // User trigger.
  input  wire logic [TRIG_W-1:0]   trig_delay,
  output logic                     user_trigger_output,
  // Front panel indicators.
  output logic                     ready_led,
  output logic                     acq_led,
  output logic                     net_transmit_indicator,
  output logic                     net_receive_indicator
);

  // All module registers except the accumulator memory in one record.
  typedef struct packed {
    logic [1:0]        acc_sync;
    logic [1:0]        dig_sync;
    phase_e            phase;
    logic [31:0]       beat_cnt;
    logic [7:0]        init_cnt;
    logic [ACC_AW-1:0] wr_idx;
    logic [ACC_AW-1:0] rd_idx;
    logic [15:0]       scans_done;
    logic              acc_prev;
    logic [TRIG_W-1:0] trig_cnt;
    logic              trig_arm;
    logic              trig;
    logic [7:0]        rack_d;
    logic              rack_v;
    logic [7:0]        map;
    logic              map_v;
    logic [7:0]        amp_d;
    logic              amp_v;
    logic              rx_seen;
    out_word_s [1:0]   buf_word;
    logic              buf_head;
    logic [1:0]        buf_cnt;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Working accumulation memory; a slice of the full working memory.
  logic [ACC_W-1:0] acc_mem [ACC_DEPTH];

  // Sample width of the selected variant; basic variant drops the top bits.
  function automatic logic [ACC_W-1:0] widen(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] m;
    m = EXTENDED ? s : {{(SAMPLE_W-BASIC_W){s[BASIC_W-1]}}, s[BASIC_W-1:0]};
    return {{(ACC_W-SAMPLE_W){m[SAMPLE_W-1]}}, m};
  endfunction : widen

  logic              accept_s;
  logic              dig_s;
  logic              take;
  logic [ACC_W-1:0]  pair_sum;
  logic              buf_push;
  logic              buf_pop;
  logic              buf_full;
  logic [ACC_AW-1:0] last_idx;

  assign accept_s = state_reg.acc_sync[1];
  assign dig_s    = state_reg.dig_sync[1];
  assign last_idx = ACC_AW'(SCAN_LEN - 1);
  // Only the synchronised gate is looked at; both streams enter per clock.
  assign take     = accept_s && sample_valid && state_reg.phase == ST_ACQ;
  assign pair_sum = dig_s ? widen(sample_a) + widen(sample_b) : '0;
  assign buf_full = state_reg.buf_cnt == 2'h2;
  assign buf_push = state_reg.phase == ST_SEND && !buf_full;
  assign buf_pop  = host_valid && host_ready;

  // Next-state logic for the whole block.
  always_comb begin
    state_next = state_reg;
    state_next.acc_sync = {state_reg.acc_sync[0], accept_gate};
    state_next.dig_sync = {state_reg.dig_sync[0], digitizer_gate};
    state_next.acc_prev = accept_s;
    state_next.rack_v   = 1'b0;
    state_next.map_v    = 1'b0;
    state_next.amp_v    = 1'b0;
    state_next.trig     = 1'b0;
    state_next.rx_seen  = host_rx_valid;
    // Heartbeat runs only once initialisation has finished.
    if (state_reg.phase != ST_INIT) begin
      state_next.beat_cnt = (state_reg.beat_cnt == PERIOD_CYC - 1) ? '0
                            : state_reg.beat_cnt + 32'h1;
    end
    unique case (state_reg.phase)
      ST_INIT: begin
        // Memory is cleared word by word, indicators stay dark.
        state_next.wr_idx = state_reg.wr_idx + ACC_AW'(1);
        if (state_reg.wr_idx == ACC_AW'(ACC_DEPTH - 1)) begin
          state_next.phase = ST_IDLE;
          state_next.wr_idx = ADDR_ZERO;
        end
      end
      ST_IDLE: begin
        if (accept_s && !state_reg.acc_prev) begin
          state_next.phase      = ST_ACQ;
          state_next.scans_done = '0;
          state_next.wr_idx     = ADDR_ZERO;
          state_next.trig_arm   = 1'b1;
          state_next.trig_cnt   = trig_delay;
        end
      end
      ST_ACQ: begin
        if (take) begin
          if (state_reg.wr_idx == last_idx) begin
            state_next.wr_idx     = ADDR_ZERO;
            state_next.scans_done = state_reg.scans_done + 16'h1;
            if (state_reg.scans_done + 16'h1 >= scan_count) begin
              state_next.phase  = ST_SEND;
              state_next.rd_idx = ADDR_ZERO;
            end
          end else begin
            state_next.wr_idx = state_reg.wr_idx + ACC_AW'(1);
          end
        end
      end
      ST_SEND: begin
        if (buf_push) begin
          state_next.rd_idx = state_reg.rd_idx + ACC_AW'(1);
          if (state_reg.rd_idx == last_idx) begin
            state_next.phase = ST_IDLE;
          end
        end
      end
    endcase
    // Two-entry output buffer so a host stall loses no word.
    if (buf_push) begin
      state_next.buf_word[state_reg.buf_head ^ state_reg.buf_cnt[0]] =
        '{link_copy: EXTENDED, data: acc_mem[state_reg.rd_idx]};
    end
    if (buf_pop) begin
      state_next.buf_head = ~state_reg.buf_head;
    end
    state_next.buf_cnt = state_reg.buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    // Programmable trigger fires once a set delay after acquisition start.
    if (EXTENDED && state_reg.trig_arm) begin
      if (state_reg.trig_cnt == '0) begin
        state_next.trig     = 1'b1;
        state_next.trig_arm = 1'b0;
      end else begin
        state_next.trig_cnt = state_reg.trig_cnt - TRIG_W'(1);
      end
    end
    // Rack master relay, discovery and display forwarding.
    if (host_rx_valid) begin
      state_next.rack_d = host_rx_data;
      state_next.rack_v = 1'b1;
    end
    if (cfg_command) begin
      state_next.map   = slot_present;
      state_next.map_v = 1'b1;
    end
    if (amp_display_valid) begin
      state_next.amp_d = amp_display_byte;
      state_next.amp_v = 1'b1;
    end
  end

  // State register; memory writes kept beside it without reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Accumulator memory: cleared in init, first scan overwrites, later scans add.
  always_ff @(posedge sys_clk) begin
    if (state_reg.phase == ST_INIT) begin
      acc_mem[state_reg.wr_idx] <= '0;
    end else if (take) begin
      acc_mem[state_reg.wr_idx] <= (state_reg.scans_done == '0) ? pair_sum
                                   : acc_mem[state_reg.wr_idx] + pair_sum;
    end
  end

  // Outputs; everything runs on the single backplane-derived clock.
  assign host_data   = state_reg.buf_word[state_reg.buf_head].data;
  assign host_valid  = state_reg.buf_cnt != 2'h0;
  assign link_data   = host_data;
  assign link_valid  = buf_pop && state_reg.buf_word[state_reg.buf_head].link_copy;
  assign rack_data   = state_reg.rack_d;
  assign rack_valid  = state_reg.rack_v;
  assign rack_map    = state_reg.map;
  assign rack_map_valid = state_reg.map_v;
  assign amp_fwd_data   = state_reg.amp_d;
  assign amp_fwd_valid  = state_reg.amp_v;
  assign user_trigger_output = state_reg.trig;
  assign ready_led   = state_reg.phase != ST_INIT && state_reg.beat_cnt >= OFF_CYC;
  assign acq_led     = state_reg.phase == ST_ACQ;
  // Network lamps stay dark through init even if traffic already arrives.
  assign net_transmit_indicator = state_reg.phase != ST_INIT
                                  && (host_valid || state_reg.amp_v);
  assign net_receive_indicator  = state_reg.phase != ST_INIT
                                  && state_reg.rx_seen;

  // Checks on the guarded behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ready_dark_init_a: assert property (state_reg.phase == ST_INIT
    |-> !ready_led && !acq_led && !net_transmit_indicator && !net_receive_indicator)
    else $error("Indicator lit during init.");
  ready_off_a: assert property (state_reg.phase != ST_INIT
                                && state_reg.beat_cnt < OFF_CYC |-> !ready_led)
    else $error("Ready not off in gap.");
  no_take_gate_a: assert property (!accept_s |-> !take)
    else $error("Sample taken while gate low.");
  zero_fill_a: assert property (!dig_s |-> pair_sum == '0)
    else $error("Non-zero data with digitizer gate low.");
  acq_start_a: assert property (state_reg.phase == ST_IDLE && accept_s
                                && !state_reg.acc_prev |=> acq_led)
    else $error("Acquisition did not start.");
  buf_hold_a: assert property (host_valid && !host_ready
                               |=> host_valid && $stable(host_data))
    else $error("Buffered word lost under stall.");
  tx_led_a: assert property (host_valid |-> net_transmit_indicator)
    else $error("Transmit indicator dark while sending.");
  rx_led_a: assert property (host_rx_valid |=> rack_valid
                             && (net_receive_indicator || state_reg.phase == ST_INIT))
    else $error("Receive not indicated or relayed.");
  map_a: assert property (cfg_command
                          |=> rack_map_valid && rack_map == $past(slot_present))
    else $error("Rack map not captured.");
  trig_pulse_a: assert property (user_trigger_output |=> !user_trigger_output)
    else $error("Trigger longer than one cycle.");
  // Counter bounds and init exit; a stuck init would leave every indicator dark forever.
  beat_range_a: assert property (state_reg.beat_cnt < PERIOD_CYC)
    else $error("Heartbeat counter out of range.");
  init_quiet_a: assert property (state_reg.phase == ST_INIT
                                 |-> !host_valid && !link_valid && !user_trigger_output)
    else $error("Output active during init.");
  init_done_a: assert property (state_reg.phase == ST_INIT
                                && state_reg.wr_idx == ACC_AW'(ACC_DEPTH - 1)
                                |=> state_reg.phase == ST_IDLE)
    else $error("Init did not finish.");
  basic_quiet_a: assert property (!EXTENDED
                                  |-> !user_trigger_output && !link_valid)
    else $error("Extended-only output active in basic variant.");

  acq_cov: cover property (state_reg.phase == ST_ACQ ##1 state_reg.phase == ST_SEND);
  stall_cov: cover property (buf_full && !host_ready);
  beat_cov: cover property (!ready_led && state_reg.phase != ST_INIT ##1 ready_led);
  trig_cov: cover property (user_trigger_output);
  relay_cov: cover property (rack_valid && rack_map_valid && amp_fwd_valid);

endmodule : receiver_sample_intake_status

// [verif/sample_source_model.sv]
// Model of the observe signal generator and the receiver digitizer.
// Assumes the bench calls its tasks from a process clocked by sys_clk.
module sample_source_model
  import rx_intake_pkg::*;
(
  // Clock.
  input  wire logic           sys_clk,
  // Gates and sample streams toward the block.
  output logic                accept_gate,
  output logic                digitizer_gate,
  output logic [SAMPLE_W-1:0] sample_a,
  output logic [SAMPLE_W-1:0] sample_b,
  output logic                sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines start quiet; idle data toggles so a stale word never looks fresh.
  initial begin
    accept_gate    = 1'b0;
    digitizer_gate = 1'b0;
    sample_a       = 16'h0000;
    sample_b       = 16'hffff;
    sample_valid   = 1'b0;
  end

  // Valid words with the accept gate low must be dropped by the block.
  task automatic noise(input int k);
    for (int i = 0; i < k; i++) begin
      sample_a     <= 16'($urandom);
      sample_b     <= 16'($urandom);
      sample_valid <= 1'b1;
      @(posedge sys_clk);
    end
    sample_valid <= 1'b0;
  endtask : noise

  // One acquisition: accept gate opens, digitizer gate set to dg, n samples back to back, accept gate closes (digitizer gate stays as set).
  task automatic acquire(input int n, input logic dg);
    @(posedge sys_clk);
    accept_gate    <= 1'b1;
    digitizer_gate <= dg;
    // Five edges cover the two-stage synchroniser and the start cycle.
    repeat (5) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sample_a     <= 16'($urandom % 32768);
      sample_b     <= 16'($urandom % 32768);
      sample_valid <= 1'b1;
      @(posedge sys_clk);
    end
    sample_valid <= 1'b0;
    sample_a     <= ~sample_a;
    sample_b     <= ~sample_b;
    repeat (4) @(posedge sys_clk);
    accept_gate  <= 1'b0;
  endtask : acquire
endmodule : sample_source_model

// [verif/tb_receiver_sample_intake_status.sv]
// Self-checking bench for the sample intake and status block.
// Assumes short heartbeat and scan parameters so the run stays brief.
module tb_receiver_sample_intake_status
  import rx_intake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 50, OFF = 4, SL = 4;
  logic sys_clk = 1'b0, rst_n = 1'b0, acg, dgg, sv, host_ready = 1'b0;
  logic [15:0] sa, sb, scan_count = 16'h0001, trig_delay = 16'h0003;
  logic [7:0] rxd = 8'h00, slot = 8'h00, ampb = 8'h00;
  logic rxv = 1'b0, cfg = 1'b0, ampv = 1'b0;
  logic [31:0] host_data, link_data;
  logic host_valid, link_valid, ready_led, acq_led, ntx, nrx, trg;
  logic [7:0] rack_data, rack_map, amp_fwd_data;
  logic rack_valid, rack_map_valid, amp_fwd_valid;
  int err_count = 0, n_checks = 0, idx = 0, scans = 0, links = 0, words = 0, hi;
  int acc [SL];
  logic [31:0] q[$];
  bit tx_seen = 0;
  int cyc = 0, t_acq = 0, trigs = 0;
  int acc_b [SL];
  logic [31:0] qb[$], want, b_data;
  logic b_valid, b_link, b_trg;
  bit acq_q = 0;

  // Basic variant keeps the low 12 bits as a signed sample.
  function automatic int basic_val(input logic [15:0] s);
    return s[BASIC_W-1] ? int'(s[BASIC_W-1:0]) - (1 << BASIC_W) : int'(s[BASIC_W-1:0]);
  endfunction : basic_val

  receiver_sample_intake_status #(.PERIOD_CYC(P), .OFF_CYC(OFF), .SCAN_LEN(SL)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .accept_gate(acg), .digitizer_gate(dgg),
    .sample_a(sa), .sample_b(sb), .sample_valid(sv), .scan_count(scan_count),
    .host_data(host_data), .host_valid(host_valid), .host_ready(host_ready),
    .link_data(link_data), .link_valid(link_valid), .host_rx_data(rxd),
    .host_rx_valid(rxv), .rack_data(rack_data), .rack_valid(rack_valid),
    .cfg_command(cfg), .slot_present(slot), .rack_map(rack_map),
    .rack_map_valid(rack_map_valid), .amp_display_byte(ampb),
    .amp_display_valid(ampv), .amp_fwd_data(amp_fwd_data), .amp_fwd_valid(amp_fwd_valid),
    .trig_delay(trig_delay), .user_trigger_output(trg), .ready_led(ready_led),
    .acq_led(acq_led), .net_transmit_indicator(ntx), .net_receive_indicator(nrx));
  sample_source_model gen (.sys_clk(sys_clk), .accept_gate(acg), .digitizer_gate(dgg),
    .sample_a(sa), .sample_b(sb), .sample_valid(sv));
  // Basic variant on the same stimulus; it sees the same stalls as dut.
  receiver_sample_intake_status #(.EXTENDED(1'b0), .PERIOD_CYC(P), .OFF_CYC(OFF),
    .SCAN_LEN(SL)) dut_b (
    .sys_clk(sys_clk), .rst_n(rst_n), .accept_gate(acg), .digitizer_gate(dgg),
    .sample_a(sa), .sample_b(sb), .sample_valid(sv), .scan_count(scan_count),
    .host_data(b_data), .host_valid(b_valid), .host_ready(host_ready),
    .link_data(), .link_valid(b_link), .host_rx_data(rxd), .host_rx_valid(rxv),
    .rack_data(), .rack_valid(), .cfg_command(cfg), .slot_present(slot), .rack_map(),
    .rack_map_valid(), .amp_display_byte(ampb), .amp_display_valid(ampv),
    .amp_fwd_data(), .amp_fwd_valid(), .trig_delay(trig_delay),
    .user_trigger_output(b_trg), .ready_led(), .acq_led(), .net_transmit_indicator(),
    .net_receive_indicator());

  // Clock at 50 MHz.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  // Random stalls by the host exercise the two-entry buffer.
  always @(posedge sys_clk) begin
    host_ready <= ($urandom % 3) != 0;
  end

  // Reference model: sums a+b per slot over scans, zeros when gated off.
  always @(posedge sys_clk) begin
    if (rst_n && sv && acg) begin
      check("acq_led", acq_led, 1'b1);
      acc[idx] += dgg ? int'(sa) + int'(sb) : 0;
      acc_b[idx] += dgg ? basic_val(sa) + basic_val(sb) : 0;
      idx = (idx + 1) % SL;
      if (idx == 0 && ++scans == int'(scan_count)) begin
        foreach (acc[i]) q.push_back(32'(acc[i]));
        foreach (acc_b[i]) qb.push_back(32'(acc_b[i]));
        acc = '{default: 0};
        acc_b = '{default: 0};
        scans = 0;
      end
    end
    if (host_valid === 1'b1 && host_ready) begin
      words++;
      want = q.size() ? q.pop_front() : 32'hx;
      check("host_data", host_data, want);
      check("link_valid", link_valid, 1'b1);
      check("link_data", link_data, want);
      check("basic_valid", b_valid, 1'b1);
      check("basic_data", b_data, qb.size() ? qb.pop_front() : 32'hx);
      check("basic_link", b_link, 1'b0);
    end
    if (link_valid === 1'b1) links++;
    if (host_valid === 1'b1 && ntx === 1'b1) tx_seen = 1;
    // Trigger must follow acquisition start by the programmed delay plus one.
    if (acq_led === 1'b1 && !acq_q) t_acq = cyc;
    if (trg === 1'b1) begin
      trigs++;
      check("trig_delay", cyc - t_acq, 32'(trig_delay) + 32'h1);
      check("basic_trig", b_trg, 1'b0);
    end
    acq_q = (acq_led === 1'b1);
    cyc++;
  end

  // Watchdog sized well beyond the expected few hundred cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  initial begin
    void'($urandom(32'hf6e16469));
    acc = '{default: 0};
    acc_b = '{default: 0};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      // Host and amplifier traffic during init must not light the panel.
      {rxv, ampv} <= (i < 9) ? 2'b11 : 2'b00;
      #1 check("leds", {ready_led, acq_led, ntx, nrx}, 4'h0);
    end
    for (int i = 0; i < 300 && ready_led !== 1'b1; i++) @(posedge sys_clk);
    hi = 0;
    repeat (P) begin
      #1 hi += (ready_led === 1'b1);
      @(posedge sys_clk);
    end
    check("beat_on", hi, P - OFF);
    $display("test heartbeat done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      rxd <= 8'($urandom);
      slot <= 8'($urandom);
      ampb <= 8'($urandom);
      {rxv, cfg, ampv} <= 3'b111;
      @(posedge sys_clk);
      {rxv, cfg, ampv} <= 3'b000;
      #1 check("relay", {rack_valid, nrx, rack_data}, {2'b11, rxd});
      check("map", {rack_map_valid, rack_map}, {1'b1, slot});
      check("amp", {amp_fwd_valid, amp_fwd_data}, {1'b1, ampb});
    end
    $display("test relay done");
    @(posedge sys_clk);
    gen.noise(6);
    scan_count <= 16'h0003;
    trig_delay <= 16'($urandom % 16);
    gen.acquire(3 * SL, 1'b1);
    for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge sys_clk);
    scan_count <= 16'h0001;
    gen.acquire(SL, 1'b0);
    for (int i = 0; i < 400 && q.size() != 0; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    check("words", words, 2 * SL);
    check("link", links, 2 * SL);
    check("tx_led", tx_seen, 1'b1);
    check("trigs", trigs, 2);
    check("acq_idle", acq_led, 1'b0);
    $display("test acquisition done");
    test_done();
  end
endmodule : tb_receiver_sample_intake_status
